// File: src/mie_pkg.sv
// Package for the metering interrupt enable block: SFR addresses, bit positions, reset values.
// Assumes an 8-bit SFR bus from the core with byte addresses.
package mie_pkg;
    localparam logic [7:0] MIE_ADDR_EN_LOW = 8'hD9;
    localparam logic [7:0] MIE_ADDR_EN_MID = 8'hDA;
    localparam logic [7:0] MIE_ADDR_EN_HIGH = 8'hDB;
    localparam logic [7:0] MIE_ADDR_ST_LOW = 8'hDC;
    localparam logic [7:0] MIE_ADDR_GAIN = 8'hE8;
    localparam logic [7:0] MIE_RST_EN = 8'h00;
    localparam logic [7:0] MIE_RST_GAIN = 8'h00;
    localparam int MIE_SUMMARY_BIT = 7;
    localparam logic [7:0] MIE_LOW_MASK = 8'h3F;
    localparam logic [7:0] MIE_HIGH_MASK = 8'h3F;
    localparam int MIE_GAIN_I_LSB = 0;
    localparam int MIE_GAIN_V_LSB = 5;
    localparam int MIE_GAIN_W = 3;
    localparam logic [2:0] MIE_GAIN_MAX = 3'h4;
    localparam int MIE_SAMPLE_DIV = 5;
    localparam int MIE_DIV_W = 3;
    localparam int MIE_DATA_W = 24;
    localparam int MIE_DEC_LOG2 = 5;
    typedef enum logic [1:0] {
        MIE_GAIN_X1 = 2'b00,
        MIE_GAIN_OK = 2'b01
    } mie_gain_st_t;
endpackage

// File: src/mie_sinc.sv
// One converter channel: bit stream averaging into a signed sample word.
// Assumes bit_in is valid when samp_en pulses; sample rate set by the caller.
`timescale 1ns/1ps
`default_nettype none
module mie_sinc #(
    parameter int DATA_W = mie_pkg::MIE_DATA_W,
    parameter int DEC_LOG2 = mie_pkg::MIE_DEC_LOG2
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Modulator side.
    input wire logic samp_en,
    input wire logic power_down,
    input wire logic bit_in,
    // Filtered output.
    output logic [DATA_W-1:0] word_q,
    output logic word_vld_q
);
    import mie_pkg::*;
    logic [DEC_LOG2-1:0] cnt_q;
    logic [DEC_LOG2:0] ones_q;
    logic [DEC_LOG2:0] ones_d;
    logic signed [DEC_LOG2+1:0] centred;
    logic signed [DATA_W-1:0] level;

    assign ones_d = ones_q + {{DEC_LOG2{1'b0}}, bit_in};
    // Ones count minus half the window gives a signed level; the shift after the widening cast
    // drops every extension bit, so the level's low six bits land at the top of the word, sign first.
    assign centred = signed'({1'b0, ones_d}) - signed'((DEC_LOG2 + 2)'(1) << (DEC_LOG2 - 1));
    assign level = DATA_W'(centred) <<< (DATA_W - DEC_LOG2 - 1);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            ones_q <= '0;
            word_q <= '0;
            word_vld_q <= 1'b0;
        end else begin
            word_vld_q <= 1'b0;
            if (power_down) begin
                cnt_q <= '0;
                ones_q <= '0;
            end else if (samp_en) begin
                cnt_q <= cnt_q + 1'b1;
                if (&cnt_q) begin
                    word_q <= level;
                    word_vld_q <= 1'b1;
                    ones_q <= '0;
                end else begin
                    ones_q <= ones_d;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: src/mie_top.sv
// Metering interrupt enable gating, gain select register and converter digital side.
// Assumes an 8-bit SFR bus with single-cycle write and read strobes; flags come from
// the metering engine as levels and are cleared there.
`timescale 1ns/1ps
`default_nettype none
module mie_top #(
    parameter int DATA_W = mie_pkg::MIE_DATA_W
) (
    // Clock (4.096 MHz metering clock) and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // SFR bus from the core.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Metering status flags, held by the metering engine until cleared.
    input wire logic [7:0] status_low,
    input wire logic [7:0] status_mid,
    input wire logic [7:0] status_high,
    // Power modes.
    input wire logic battery_power_mode,
    input wire logic sleep_power_mode,
    // Modulator bit streams.
    input wire logic mod_bit_i,
    input wire logic mod_bit_v,
    // Outputs to the core and the analog front end.
    output logic meter_irq_pending,
    output logic meter_irq_summary,
    output logic [mie_pkg::MIE_GAIN_W-1:0] gain_i_q,
    output logic [mie_pkg::MIE_GAIN_W-1:0] gain_v_q,
    output logic adc_power_down,
    output logic mod_sample_en,
    output logic [DATA_W-1:0] wave_i_q,
    output logic [DATA_W-1:0] wave_v_q,
    output logic wave_vld,
    output logic [DATA_W-1:0] dsp_i,
    output logic [DATA_W-1:0] dsp_v,
    output logic dsp_vld
);
    import mie_pkg::*;

    logic [7:0] meter_irq_enable_low_q;
    logic [7:0] meter_irq_enable_mid_q;
    logic [7:0] meter_irq_enable_high_q;
    logic [7:0] amplifier_gain_select_q;
    logic [MIE_DIV_W-1:0] div_q;
    logic [DATA_W-1:0] word_i;
    logic [DATA_W-1:0] word_v;
    logic vld_i;
    logic vld_v;
    logic [7:0] hit_low;
    logic [7:0] hit_mid;
    logic [7:0] hit_high;
    logic any_hit;

    // Enable registers; reserved enable bits stay zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meter_irq_enable_low_q <= MIE_RST_EN;
            meter_irq_enable_mid_q <= MIE_RST_EN;
            meter_irq_enable_high_q <= MIE_RST_EN;
        end else if (sfr_wr) begin
            if (sfr_addr == MIE_ADDR_EN_LOW) begin
                meter_irq_enable_low_q <= sfr_wdata & MIE_LOW_MASK;
            end
            if (sfr_addr == MIE_ADDR_EN_MID) begin
                meter_irq_enable_mid_q <= sfr_wdata;
            end
            if (sfr_addr == MIE_ADDR_EN_HIGH) begin
                meter_irq_enable_high_q <= sfr_wdata & MIE_HIGH_MASK;
            end
        end
    end

    // Gain codes above four (x16) are refused so the amplifier never sees an undefined code.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            amplifier_gain_select_q <= MIE_RST_GAIN;
        end else if (sfr_wr && sfr_addr == MIE_ADDR_GAIN) begin
            if (sfr_wdata[MIE_GAIN_I_LSB +: MIE_GAIN_W] <= MIE_GAIN_MAX) begin
                amplifier_gain_select_q[MIE_GAIN_I_LSB +: MIE_GAIN_W] <=
                    sfr_wdata[MIE_GAIN_I_LSB +: MIE_GAIN_W];
            end
            if (sfr_wdata[MIE_GAIN_V_LSB +: MIE_GAIN_W] <= MIE_GAIN_MAX) begin
                amplifier_gain_select_q[MIE_GAIN_V_LSB +: MIE_GAIN_W] <=
                    sfr_wdata[MIE_GAIN_V_LSB +: MIE_GAIN_W];
            end
        end
    end

    assign gain_i_q = amplifier_gain_select_q[MIE_GAIN_I_LSB +: MIE_GAIN_W];
    assign gain_v_q = amplifier_gain_select_q[MIE_GAIN_V_LSB +: MIE_GAIN_W];

    // Per-flag gating; the summary bit is combinational so it drops the cycle the flags clear.
    assign hit_low = status_low & meter_irq_enable_low_q;
    assign hit_mid = status_mid & meter_irq_enable_mid_q;
    assign hit_high = status_high & meter_irq_enable_high_q;
    assign any_hit = (|hit_low) | (|hit_mid) | (|hit_high);
    assign meter_irq_pending = any_hit;
    assign meter_irq_summary = any_hit;

    // Read mux; status low shows the live summary in bit 7.
    always_comb begin
        sfr_hit = 1'b1;
        sfr_rdata = 8'h00;
        case (sfr_addr)
            MIE_ADDR_EN_LOW: sfr_rdata = meter_irq_enable_low_q;
            MIE_ADDR_EN_MID: sfr_rdata = meter_irq_enable_mid_q;
            MIE_ADDR_EN_HIGH: sfr_rdata = meter_irq_enable_high_q;
            MIE_ADDR_ST_LOW: begin
                sfr_rdata = status_low & 8'h3F;
                sfr_rdata[MIE_SUMMARY_BIT] = any_hit;
            end
            MIE_ADDR_GAIN: sfr_rdata = amplifier_gain_select_q;
            default: sfr_hit = 1'b0;
        endcase
        if (!sfr_rd) begin
            sfr_hit = 1'b0;
            sfr_rdata = 8'h00;
        end
    end

    // Low-power modes stop the converters and keep the divider cleared to zero.
    assign adc_power_down = battery_power_mode | sleep_power_mode;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_q <= '0;
        end else if (adc_power_down || div_q == MIE_DIV_W'(MIE_SAMPLE_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign mod_sample_en = !adc_power_down && div_q == MIE_DIV_W'(MIE_SAMPLE_DIV - 1);

    mie_sinc #(.DATA_W(DATA_W), .DEC_LOG2(MIE_DEC_LOG2)) u_sinc_i (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .samp_en(mod_sample_en),
        .power_down(adc_power_down),
        .bit_in(mod_bit_i),
        .word_q(word_i),
        .word_vld_q(vld_i)
    );

    mie_sinc #(.DATA_W(DATA_W), .DEC_LOG2(MIE_DEC_LOG2)) u_sinc_v (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .samp_en(mod_sample_en),
        .power_down(adc_power_down),
        .bit_in(mod_bit_v),
        .word_q(word_v),
        .word_vld_q(vld_v)
    );

    // Both channels share one divider so their words are always aligned.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wave_i_q <= '0;
            wave_v_q <= '0;
            wave_vld <= 1'b0;
        end else begin
            wave_vld <= vld_i & vld_v;
            if (vld_i && vld_v) begin
                wave_i_q <= word_i;
                wave_v_q <= word_v;
            end
        end
    end

    assign dsp_i = word_i;
    assign dsp_v = word_v;
    assign dsp_vld = vld_i & vld_v;

    a_summary_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
        meter_irq_summary == ((|(status_low & meter_irq_enable_low_q))
        || (|(status_mid & meter_irq_enable_mid_q))
        || (|(status_high & meter_irq_enable_high_q))))
        else $error("summary mismatch");
    a_fault_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_low[5] && meter_irq_enable_low_q[5]) |-> meter_irq_pending)
        else $error("fault change not gated");
    a_no_enable_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        (meter_irq_enable_low_q == 8'h00 && meter_irq_enable_mid_q == 8'h00
        && meter_irq_enable_high_q == 8'h00) |-> !meter_irq_pending)
        else $error("interrupt without enable");
    a_pulse_two_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_mid[7] && meter_irq_enable_mid_q[7]) |-> meter_irq_pending)
        else $error("pulse two not gated");
    a_wave_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_high[5] && meter_irq_enable_high_q[5])[*2] |-> meter_irq_pending)
        else $error("waveform interrupt dropped");
    a_power_down_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        adc_power_down |=> !mod_sample_en && div_q == 3'h0)
        else $error("converter ran in low power");
    a_sample_spacing: assert property (@(posedge clk_sys) disable iff (!resetn)
        (mod_sample_en && !adc_power_down) |=> !mod_sample_en [*4])
        else $error("sample rate wrong");
    a_gain_range: assert property (@(posedge clk_sys) disable iff (!resetn)
        gain_i_q <= 3'h4 && gain_v_q <= 3'h4)
        else $error("gain code out of range");
    a_gain_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sfr_wr && sfr_addr == MIE_ADDR_GAIN && sfr_wdata[2:0] <= MIE_GAIN_MAX)
        |=> gain_i_q == $past(sfr_wdata[2:0]))
        else $error("current gain not written");
    a_wave_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        (vld_i && vld_v) |=> wave_vld && wave_i_q == $past(word_i))
        else $error("waveform word not loaded");

    // Each enabled flag must raise the pending interrupt on its own.
    a_reactive_sign_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_low[4] && meter_irq_enable_low_q[4]) |-> meter_irq_pending)
        else $error("reactive sign change not gated");
    a_active_sign_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_low[3] && meter_irq_enable_low_q[3]) |-> meter_irq_pending)
        else $error("active sign change not gated");
    a_no_load_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (|(status_low[2:0] & meter_irq_enable_low_q[2:0])) |-> meter_irq_pending)
        else $error("no-load flag not gated");
    a_pulse_one_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_mid[6] && meter_irq_enable_mid_q[6]) |-> meter_irq_pending)
        else $error("pulse one not gated");
    a_overflow_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (|(status_mid[5:3] & meter_irq_enable_mid_q[5:3])) |-> meter_irq_pending)
        else $error("overflow flag not gated");
    a_half_full_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (|(status_mid[2:0] & meter_irq_enable_mid_q[2:0])) |-> meter_irq_pending)
        else $error("half-full flag not gated");
    a_wave_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_high[5] && meter_irq_enable_high_q[5]) |-> meter_irq_pending)
        else $error("waveform flag not gated");
    a_peak_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (|(status_high[4:3] & meter_irq_enable_high_q[4:3])) |-> meter_irq_pending)
        else $error("peak flag not gated");
    a_cycle_end_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_high[2] && meter_irq_enable_high_q[2]) |-> meter_irq_pending)
        else $error("cycle end flag not gated");
    a_zero_cross_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (|(status_high[1:0] & meter_irq_enable_high_q[1:0])) |-> meter_irq_pending)
        else $error("zero-cross flag not gated");

    // Enables, summary and read-back.
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        meter_irq_enable_low_q[7:6] == 2'b00 && meter_irq_enable_high_q[7:6] == 2'b00)
        else $error("reserved enable bit set");
    a_enable_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !sfr_wr |=> $stable(meter_irq_enable_mid_q))
        else $error("enable changed without write");
    a_summary_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_low == 8'h00 && status_mid == 8'h00 && status_high == 8'h00)
        |-> !meter_irq_summary)
        else $error("summary stuck without flags");
    a_summary_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sfr_rd && sfr_addr == MIE_ADDR_ST_LOW)
        |-> sfr_rdata[MIE_SUMMARY_BIT] == meter_irq_summary)
        else $error("summary read-back wrong");

    // Gain register and converter side.
    a_voltage_gain_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sfr_wr && sfr_addr == MIE_ADDR_GAIN && sfr_wdata[7:5] <= MIE_GAIN_MAX)
        |=> gain_v_q == $past(sfr_wdata[7:5]))
        else $error("voltage gain not written");
    a_gain_refused: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sfr_wr && sfr_addr == MIE_ADDR_GAIN && sfr_wdata[2:0] > MIE_GAIN_MAX)
        |=> $stable(gain_i_q))
        else $error("refused gain code taken");
    a_gain_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(sfr_wr && sfr_addr == MIE_ADDR_GAIN) |=> $stable(amplifier_gain_select_q))
        else $error("gain changed without write");
    a_low_power_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
        (battery_power_mode || sleep_power_mode) |-> adc_power_down && !mod_sample_en)
        else $error("low power mode ignored");
    a_power_down_silent: assert property (@(posedge clk_sys) disable iff (!resetn)
        adc_power_down |=> !dsp_vld)
        else $error("word produced in low power");
    a_dsp_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        dsp_vld |=> !dsp_vld)
        else $error("word strobe too long");
    a_wave_voltage: assert property (@(posedge clk_sys) disable iff (!resetn)
        (vld_i && vld_v) |=> wave_v_q == $past(word_v))
        else $error("voltage word not loaded");
endmodule
`default_nettype wire

// File: bench/mie_flag_model.sv
// Metering engine stand-in: status flags held as levels until the core clears them.
// Assumes set and clear masks arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module mie_flag_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Set and clear masks from the bench acting as core.
    input wire logic [23:0] flag_set,
    input wire logic [23:0] flag_clr,
    // Flag levels to the block.
    output logic [7:0] status_low,
    output logic [7:0] status_mid,
    output logic [7:0] status_high
);
    // A flag never drops by itself, so its interrupt lasts until the core clears it.
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
            {status_high, status_mid, status_low} <= 24'h000000;
        else
            {status_high, status_mid, status_low} <=
                ({status_high, status_mid, status_low} | flag_set) & ~flag_clr;
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the metering interrupt enable block.
// Assumes the bench acts as core on the SFR bus and drives the modulator bits itself.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mie_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, bat = 1'b0, slp = 1'b0;
    logic lvl = 1'b1, hit, pend, summ, pdn, sen, wvld, dvld, hq;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, sl, sm, sh, rq;
    logic [23:0] fset = 24'h000000, fclr = 24'h000000, wi, wv, di, dv;
    logic [2:0] gi, gv;
    int failures = 0, num_checks = 0, cycles = 0;
    mie_top mie_top_i (.clk_sys(clk_sys), .resetn(resetn), .sfr_addr(addr), .sfr_wr(wr),
        .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata), .sfr_hit(hit), .status_low(sl),
        .status_mid(sm), .status_high(sh), .battery_power_mode(bat), .sleep_power_mode(slp),
        .mod_bit_i(lvl), .mod_bit_v(~lvl), .meter_irq_pending(pend), .meter_irq_summary(summ),
        .gain_i_q(gi), .gain_v_q(gv), .adc_power_down(pdn), .mod_sample_en(sen), .wave_i_q(wi),
        .wave_v_q(wv), .wave_vld(wvld), .dsp_i(di), .dsp_v(dv), .dsp_vld(dvld));
    mie_flag_model mie_flag_model_i (.clk_sys(clk_sys), .resetn(resetn), .flag_set(fset),
        .flag_clr(fclr), .status_low(sl), .status_mid(sm), .status_high(sh));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t ns: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {addr, wd, wr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic sfr_r(input logic [7:0] a);
        @(posedge clk_sys);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk_sys);
        {rq, hq} = {rdata, hit};
        rd <= 1'b0;
    endtask
    task automatic flags(input logic [23:0] s, input logic [23:0] c);
        @(posedge clk_sys);
        {fset, fclr} <= {s, c};
        @(posedge clk_sys);
        {fset, fclr} <= 48'h000000000000;
        @(posedge clk_sys);
    endtask
    task automatic t_gate;
        logic [7:0] a [5] = '{MIE_ADDR_EN_LOW, MIE_ADDR_EN_MID, MIE_ADDR_EN_HIGH, MIE_ADDR_GAIN,
            8'h00};
        logic [7:0] m [3] = '{MIE_LOW_MASK, 8'hFF, MIE_HIGH_MASK};
        for (int g = 0; g < 5; g++) begin
            sfr_r(a[g]);
            check({hq, rq}, {g < 4, MIE_RST_EN});
        end
        // Every other flag is raised first, so a wrong bit mapping shows as a stray interrupt.
        for (int g = 0; g < 3; g++) begin
            for (int b = 0; b < 8; b++) begin
                sfr_w(a[g], 8'h01 << b);
                sfr_r(a[g]);
                check(rq, (8'h01 << b) & m[g]);
                flags(~(24'h000001 << (8 * g + b)), 24'h000000);
                check(pend, 1'b0);
                flags(24'h000001 << (8 * g + b), 24'h000000);
                check({pend, summ}, {2{m[g][b]}});
                sfr_r(MIE_ADDR_ST_LOW);
                check({hq, rq}, {1'b1, m[g][b], 7'h3F});
                flags(24'h000000, 24'hFFFFFF);
            end
            // Leave this register quiet, or its last enable would trip the next group.
            sfr_w(a[g], 8'h00);
        end
    endtask
    task automatic t_wave;
        sfr_w(MIE_ADDR_EN_HIGH, 8'h20);
        flags(24'h200000, 24'h000000);
        repeat (6) @(posedge clk_sys);
        check(pend, 1'b1);
        flags(24'h000000, 24'h200000);
        check({pend, summ}, 2'b00);
    endtask
    task automatic t_gain;
        logic [7:0] v;
        for (int c = 0; c < 5; c++) begin
            v = {3'(c), 2'b00, 3'(4 - c)};
            sfr_w(MIE_ADDR_GAIN, v);
            sfr_r(MIE_ADDR_GAIN);
            check({rq, gv, gi}, {v, 3'(c), 3'(4 - c)});
        end
        sfr_w(MIE_ADDR_GAIN, {3'h2, 2'b11, 3'h7});
        sfr_r(MIE_ADDR_GAIN);
        check({rq, gv, gi}, {8'h40, 3'h2, 3'h0});
    endtask
    task automatic word(input logic [47:0] exp);
        for (int i = 0; i < 400 && dvld !== 1'b1; i++) @(posedge clk_sys);
        check({dvld, di, dv}, {1'b1, exp});
        @(posedge clk_sys);
        check({wvld, wi, wv}, {1'b1, exp});
    endtask
    task automatic t_conv;
        int n;
        for (n = 0; n < 10 && sen !== 1'b1; n++) @(posedge clk_sys);
        @(posedge clk_sys);
        for (n = 1; n < 10 && sen !== 1'b1; n++) @(posedge clk_sys);
        check(n, 5);
        // All ones is full positive scale, half the signed range; all zeros the negative.
        word({24'h400000, 24'hC00000});
        // The level flips before the next window's first sample, so that window is clean.
        lvl <= 1'b0;
        word({24'hC00000, 24'h400000});
        for (int p = 1; p < 3; p++) begin
            {bat, slp} <= 2'(p);
            repeat (3) @(posedge clk_sys);
            for (n = 0; n < 12 && sen !== 1'b1; n++) @(posedge clk_sys);
            check({pdn, sen}, 2'b10);
        end
    endtask
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cycles <= cycles + 1;
    initial begin
        wait (cycles == 5000);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        t_gate();
        t_wave();
        t_gain();
        t_conv();
        print_verdict();
    end
endmodule
`default_nettype wire
